// ==== qlsm_pkg.sv ====
// shared constants, state type and lane helpers for the quad lane serial master
package qlsm_pkg;

    localparam int         CLK_PERIOD_NS = 50;
    localparam int         SCK_HALF_NS   = 200;
    localparam int         SCK_HALF_CYC  = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] HALF_LAST     = 3'(SCK_HALF_CYC - 1);

    localparam logic [1:0] MODE_SINGLE   = 2'h0;
    localparam logic [1:0] MODE_DUAL     = 2'h1;
    localparam logic [1:0] MODE_QUAD     = 2'h2;

    localparam logic [4:0] CMD_BITS      = 5'h08;
    localparam logic [4:0] ADDR_BITS     = 5'h18;
    localparam logic [4:0] BYTE_BITS     = 5'h08;

    localparam logic       SELECT_IDLE   = 1'b1;
    localparam logic       SCK_IDLE      = 1'b0;
    localparam logic [3:0] SYNC_RESET    = 4'h0;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_CMD  = 5'b00010,
        ST_ADDR = 5'b00100,
        ST_DATA = 5'b01000,
        ST_GAP  = 5'b10000
    } qlsm_state_type;

    // lanes in use: command always one lane, address and data follow the mode
    function automatic logic [2:0] qlsm_width(input logic [1:0] mode, input qlsm_state_type st);
        if (st == ST_CMD || (mode != MODE_DUAL && mode != MODE_QUAD)) begin
            return 3'h1;
        end
        return (mode == MODE_QUAD) ? 3'h4 : 3'h2;
    endfunction : qlsm_width

    // top bits of the shifter onto the lanes, most significant on the highest lane
    function automatic logic [3:0] qlsm_place(input logic [3:0] top, input logic [2:0] w);
        if (w == 3'h4) begin
            return top;
        end
        if (w == 3'h2) begin
            return {2'h0, top[3:2]};
        end
        return {3'h0, top[3]};
    endfunction : qlsm_place

    // shift left by the lane count and take the sampled lanes in at the bottom
    function automatic logic [23:0] qlsm_shift(input logic [23:0] sh, input logic [3:0] ln,
                                               input logic [2:0] w);
        if (w == 3'h4) begin
            return {sh[19:0], ln};
        end
        if (w == 3'h2) begin
            return {sh[21:0], ln[1:0]};
        end
        return {sh[22:0], ln[1]};
    endfunction : qlsm_shift

endpackage : qlsm_pkg

// ==== qlsm_lane_sync.sv ====
// three flop input synchroniser with agreement filter for the lane pins
`timescale 1ns/1ns
module qlsm_lane_sync
    import qlsm_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic [3:0] pins,
    output logic      [3:0] filt
);
    logic [3:0] s1_reg;
    logic [3:0] s2_reg;
    logic [3:0] s3_reg;
    logic [3:0] filt_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_reg <= SYNC_RESET;
            s2_reg <= SYNC_RESET;
            s3_reg <= SYNC_RESET;
        end else begin
            s1_reg <= pins;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // a bit changes once second and third stage agree
    generate
        for (genvar i = 0; i < 4; i++) begin : g_bit
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    filt_reg[i] <= 1'b0;
                end else if (s2_reg[i] == s3_reg[i]) begin
                    filt_reg[i] <= s3_reg[i];
                end
            end
        end
    endgenerate

    assign filt = filt_reg;
endmodule : qlsm_lane_sync

// ==== qlsm_master.sv ====
// quad lane serial master: select, clock and lane pins toward an external flash
// What this block does
// - slave select is driven low while addressing the slave, high otherwise
// - single or dual mode: lane three pin is an active low pause output
// - quad mode: lane three pin is a shared data lane
// - single mode: lane one pin is input only, sampled from the slave
// - dual or quad mode: lane one pin is a shared data lane
// - single mode: lane zero pin always drives serial data out
// - dual or quad mode: lane zero pin is a shared data lane
// - single or dual mode: lane two pin is an active low write protect
// - quad mode: lane two pin is a shared data lane
// - master only: this end always sources serial clock and slave select
`timescale 1ns/1ns
module qlsm_master
    import qlsm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [1:0]  lane_mode,
    input  wire logic        start,
    input  wire logic [7:0]  cmd,
    input  wire logic        addr_en,
    input  wire logic [23:0] addr,
    input  wire logic        rd,
    input  wire logic [7:0]  len,
    input  wire logic [7:0]  tx_data,
    input  wire logic        pause_req,
    input  wire logic        wp_req,
    output logic             tx_take,
    output logic [7:0]       rx_data,
    output logic             rx_valid,
    output logic             busy,
    output logic             done,
    output logic             flash_select_n,
    output logic             serial_clock_out,
    input  wire logic        serial_out_lane0_in,
    output logic             serial_out_lane0_out,
    output logic             serial_out_lane0_oe,
    input  wire logic        serial_in_lane1_in,
    output logic             serial_in_lane1_out,
    output logic             serial_in_lane1_oe,
    input  wire logic        write_protect_n_lane2_in,
    output logic             write_protect_n_lane2_out,
    output logic             write_protect_n_lane2_oe,
    input  wire logic        pause_n_lane3_in,
    output logic             pause_n_lane3_out,
    output logic             pause_n_lane3_oe
);
    qlsm_state_type state_reg;
    qlsm_state_type state_next;
    logic [1:0]     mode_reg;
    logic           addr_en_reg;
    logic [23:0]    addr_reg;
    logic           rd_reg;
    logic [7:0]     len_reg;
    logic [23:0]    shift_reg;
    logic [23:0]    shift_next;
    logic [4:0]     bit_cnt_reg;
    logic [2:0]     half_cnt_reg;
    logic           sck_reg;
    logic           select_n_reg;
    logic [3:0]     lane_out_reg;
    logic [3:0]     lane_oe_reg;
    logic [7:0]     rx_data_reg;
    logic           rx_valid_reg;
    logic           tx_take_reg;
    logic           done_reg;
    logic           busy_reg;
    logic [3:0]     lanes_filt;
    logic [2:0]     width;
    logic           active;
    logic           tick;
    logic           fall;
    logic           last;
    logic           stall;
    logic           quad;
    logic           single;
    logic           drive;
    logic           load_byte;
    logic [3:0]     place;

    qlsm_lane_sync u_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .pins  ({pause_n_lane3_in, write_protect_n_lane2_in,
                 serial_in_lane1_in, serial_out_lane0_in}),
        .filt  (lanes_filt)
    );

    always_comb begin
        quad   = (mode_reg == MODE_QUAD);
        single = (mode_reg != MODE_QUAD) && (mode_reg != MODE_DUAL);
        width  = qlsm_width(mode_reg, state_reg);
        active = (state_reg == ST_CMD) || (state_reg == ST_ADDR) || (state_reg == ST_DATA);
        stall  = pause_req && !quad && !sck_reg;
        tick   = active && (half_cnt_reg == 3'h0) && !stall;
        fall   = tick && sck_reg;
        last   = fall && (bit_cnt_reg == {2'h0, width});
        shift_next = qlsm_shift(shift_reg, lanes_filt, width);
        state_next = state_reg;
        load_byte  = 1'b0;
        if (last) begin
            if (state_reg == ST_CMD && addr_en_reg) begin
                state_next = ST_ADDR;
            end else if (state_reg != ST_DATA ? (len_reg != 8'h00) : (len_reg > 8'h01)) begin
                state_next = ST_DATA;
                load_byte  = 1'b1;
            end else begin
                state_next = ST_GAP;
            end
        end
        drive = (state_reg == ST_CMD) || (state_reg == ST_ADDR)
                || ((state_reg == ST_DATA) && !rd_reg);
        place = qlsm_place(shift_reg[23:20], width);
    end

    // phase sequencer
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg   <= ST_IDLE;
            mode_reg    <= MODE_SINGLE;
            addr_en_reg <= 1'b0;
            addr_reg    <= 24'h000000;
            rd_reg      <= 1'b0;
            len_reg     <= 8'h00;
            shift_reg   <= 24'h000000;
            bit_cnt_reg <= 5'h00;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (start) begin
                        state_reg   <= ST_CMD;
                        mode_reg    <= lane_mode;
                        addr_en_reg <= addr_en;
                        addr_reg    <= addr;
                        rd_reg      <= rd;
                        len_reg     <= len;
                        shift_reg   <= {cmd, 16'h0000};
                        bit_cnt_reg <= CMD_BITS;
                    end
                end
                ST_CMD, ST_ADDR, ST_DATA: begin
                    if (fall) begin
                        state_reg   <= state_next;
                        shift_reg   <= shift_next;
                        bit_cnt_reg <= bit_cnt_reg - {2'h0, width};
                        if (last && state_next == ST_ADDR) begin
                            shift_reg   <= addr_reg;
                            bit_cnt_reg <= ADDR_BITS;
                        end
                        if (load_byte) begin
                            shift_reg   <= {tx_data, 16'h0000};
                            bit_cnt_reg <= BYTE_BITS;
                        end
                        if (last && state_reg == ST_DATA) begin
                            len_reg <= len_reg - 8'h01;
                        end
                    end
                end
                ST_GAP: begin
                    if (half_cnt_reg == 3'h0) begin
                        state_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // serial clock and slave select
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            half_cnt_reg <= HALF_LAST;
            sck_reg      <= SCK_IDLE;
            select_n_reg <= SELECT_IDLE;
            busy_reg     <= 1'b0;
        end else if (state_reg == ST_IDLE) begin
            half_cnt_reg <= HALF_LAST;
            sck_reg      <= SCK_IDLE;
            select_n_reg <= !start;
            busy_reg     <= start;
        end else if (state_reg == ST_GAP) begin
            half_cnt_reg <= half_cnt_reg - 3'h1;
            select_n_reg <= SELECT_IDLE;
            busy_reg     <= 1'b0;
        end else if (tick) begin
            half_cnt_reg <= HALF_LAST;
            sck_reg      <= !sck_reg;
            if (last && state_next == ST_GAP) begin
                select_n_reg <= SELECT_IDLE;
                busy_reg     <= 1'b0;
            end
        end else if (!stall) begin
            half_cnt_reg <= half_cnt_reg - 3'h1;
        end
    end

    // lane pin drivers and directions
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lane_out_reg <= 4'hc;
            lane_oe_reg  <= 4'hd;
        end else begin
            lane_out_reg[0] <= place[0];
            lane_oe_reg[0]  <= single || drive;
            lane_out_reg[1] <= place[1];
            lane_oe_reg[1]  <= !single && drive;
            lane_out_reg[2] <= quad ? place[2] : !wp_req;
            lane_oe_reg[2]  <= quad ? drive : 1'b1;
            lane_out_reg[3] <= quad ? place[3] : !pause_req;
            lane_oe_reg[3]  <= quad ? drive : 1'b1;
        end
    end

    // user side strobes
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rx_data_reg  <= 8'h00;
            rx_valid_reg <= 1'b0;
            tx_take_reg  <= 1'b0;
            done_reg     <= 1'b0;
        end else begin
            rx_valid_reg <= last && (state_reg == ST_DATA) && rd_reg;
            tx_take_reg  <= load_byte && !rd_reg;
            done_reg     <= (state_reg == ST_GAP) && (half_cnt_reg == 3'h0);
            if (last && (state_reg == ST_DATA) && rd_reg) begin
                rx_data_reg <= shift_next[7:0];
            end
        end
    end

    assign flash_select_n            = select_n_reg;
    assign serial_clock_out          = sck_reg;
    assign serial_out_lane0_out      = lane_out_reg[0];
    assign serial_out_lane0_oe       = lane_oe_reg[0];
    assign serial_in_lane1_out       = lane_out_reg[1];
    assign serial_in_lane1_oe        = lane_oe_reg[1];
    assign write_protect_n_lane2_out = lane_out_reg[2];
    assign write_protect_n_lane2_oe  = lane_oe_reg[2];
    assign pause_n_lane3_out         = lane_out_reg[3];
    assign pause_n_lane3_oe          = lane_oe_reg[3];
    assign rx_data                   = rx_data_reg;
    assign rx_valid                  = rx_valid_reg;
    assign tx_take                   = tx_take_reg;
    assign done                      = done_reg;
    assign busy                      = busy_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_launch;
        (state_reg == ST_IDLE) && start;
    endsequence
    sequence s_selected;
        (state_reg == ST_CMD) && !select_n_reg && (bit_cnt_reg == CMD_BITS);
    endsequence

    a_select_idle_high: assert property ((state_reg == ST_IDLE) |-> select_n_reg)
        else $error("select low while idle");
    a_launch_selects: assert property (s_launch |=> s_selected)
        else $error("start did not select the slave");
    a_pause_output: assert property (!quad |=> lane_oe_reg[3] &&
                                     (lane_out_reg[3] == !$past(pause_req)))
        else $error("pause pin not driven from pause request");
    a_wp_output: assert property (!quad |=> lane_oe_reg[2] &&
                                  (lane_out_reg[2] == !$past(wp_req)))
        else $error("write protect pin not driven from request");
    a_lane3_release: assert property (quad && (state_reg == ST_DATA) && rd_reg
                                      |=> !lane_oe_reg[3])
        else $error("lane three driven during quad read");
    a_lane1_input: assert property (single |=> !lane_oe_reg[1])
        else $error("lane one driven in single mode");
    a_lane1_cmd_drive: assert property (!single && (state_reg == ST_CMD)
                                        |=> lane_oe_reg[1])
        else $error("lane one not driven in command phase");
    a_lane0_single: assert property (single |=> lane_oe_reg[0])
        else $error("lane zero released in single mode");
    a_lane0_read: assert property (!single && (state_reg == ST_DATA) && rd_reg
                                   |=> !lane_oe_reg[0])
        else $error("lane zero driven during read");
    a_lane2_quad_cmd: assert property (quad && (state_reg == ST_CMD)
                                       |=> lane_oe_reg[2])
        else $error("lane two not driven in quad command");
    a_clock_in_frame: assert property ($changed(sck_reg) |-> !$past(select_n_reg))
        else $error("serial clock moved while deselected");
    a_clock_high_half: assert property ($rose(sck_reg) |-> sck_reg[*4])
        else $error("serial clock high half wrong length");
endmodule : qlsm_master

// ==== qlsm_flash_model.sv ====
// behavioural serial flash that answers reads on the lanes
`timescale 1ns/1ns
module qlsm_flash_model (
    input  wire logic       select_n,
    input  wire logic       sck,
    input  wire logic [2:0] width,
    input  wire logic [5:0] lead,
    input  wire logic [7:0] rd_byte,
    output logic      [3:0] drv_oe,
    output logic      [3:0] drv_val
);
    int         falls;
    logic [7:0] sh;
    logic       sck_d;
    // the master turns its lanes round one clock after the falling edge
    assign #75 sck_d = sck;
    initial begin
        drv_oe = 4'h0;
        drv_val = 4'h0;
    end
    // data changes on the falling edge; released lanes fall to the pull-down
    always @(negedge sck_d or posedge select_n) begin
        if (select_n) begin
            falls = 0;
            drv_oe = 4'h0;
            drv_val = 4'h0;
        end else begin
            falls++;
            if (falls == lead) sh = rd_byte;
            else if (falls > lead) sh = (sh << width) | (sh >> (4'h8 - 4'(width)));
            if (falls >= lead) begin
                drv_oe = (width == 3'h4) ? 4'hf : (width == 3'h2) ? 4'h3 : 4'h2;
                drv_val = (width == 3'h4) ? sh[7:4] : (width == 3'h2) ? {2'h0, sh[7:6]} : {2'h0, sh[7], 1'b0};
            end
        end
    end
endmodule : qlsm_flash_model

// ==== qlsm_master_test.sv ====
// self-checking bench for the quad lane serial master
`timescale 1ns/1ns
module qlsm_master_test;
    import qlsm_pkg::*;
    logic        clk, rst_b, start, addr_en, rd, pause_req, wp_req;
    logic        tx_take, rx_valid, busy, done, sel_n, sck;
    logic [1:0]  lane_mode, mode_q, mode_p, req_q, up_q;
    logic [7:0]  cmd, len, tx_data, rd_byte, rx_data;
    logic [23:0] addr;
    logic [3:0]  m_oe, m_out, f_oe, f_val, lane;
    logic [2:0]  w;
    logic [5:0]  lead;
    logic [63:0] cap;
    int          rises, fails, checked, cycles;

    qlsm_master i_qlsm_master (
        .clk(clk), .rst_b(rst_b), .lane_mode(lane_mode), .start(start), .cmd(cmd),
        .addr_en(addr_en), .addr(addr), .rd(rd), .len(len), .tx_data(tx_data),
        .pause_req(pause_req), .wp_req(wp_req), .tx_take(tx_take), .rx_data(rx_data),
        .rx_valid(rx_valid), .busy(busy), .done(done), .flash_select_n(sel_n),
        .serial_clock_out(sck),
        .serial_out_lane0_in(lane[0]), .serial_out_lane0_out(m_out[0]),
        .serial_out_lane0_oe(m_oe[0]),
        .serial_in_lane1_in(lane[1]), .serial_in_lane1_out(m_out[1]),
        .serial_in_lane1_oe(m_oe[1]),
        .write_protect_n_lane2_in(lane[2]), .write_protect_n_lane2_out(m_out[2]),
        .write_protect_n_lane2_oe(m_oe[2]),
        .pause_n_lane3_in(lane[3]), .pause_n_lane3_out(m_out[3]),
        .pause_n_lane3_oe(m_oe[3])
    );
    qlsm_flash_model i_qlsm_flash_model (
        .select_n(sel_n), .sck(sck), .width(w), .lead(lead), .rd_byte(rd_byte),
        .drv_oe(f_oe), .drv_val(f_val)
    );
    // pins carry a pull-down when nobody drives them
    assign lane = (m_oe & m_out) | (~m_oe & f_oe & f_val);

    always #25 clk = ~clk;

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_of_test();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    // capture what stands on the lanes at each rising serial clock edge
    always @(negedge sel_n) begin
        rises = 0;
        cap = '0;
    end
    always @(posedge sck) begin
        rises++;
        if (rises <= 8 || w == 3'h1) cap = {cap[62:0], lane[0]};
        else if (w == 3'h2) cap = {cap[61:0], lane[1:0]};
        else cap = {cap[59:0], lane};
    end

    // pin roles watched on every cycle
    always @(posedge clk) begin
        // the design takes the mode only with a start seen while idle
        if (start && !busy) mode_q <= lane_mode;
        mode_p <= mode_q;
        req_q <= {pause_req, wp_req};
        up_q <= {up_q[0], rst_b};
        cycles++;
        if (cycles == 20000) begin
            fails++;
            end_of_test();
        end
    end
    always @(negedge clk) begin
        if (up_q == 2'h3) begin
            chk(64'(m_oe & f_oe), 64'h0);
            chk({busy, sck & sel_n}, {~sel_n, 1'b0});
            if (mode_p != MODE_QUAD) chk({m_oe[3:2], m_out[3:2]}, {2'h3, ~req_q});
            if (mode_p != MODE_DUAL && mode_p != MODE_QUAD) chk(m_oe[1:0], 2'h1);
        end
    end

    task automatic frame(input logic [1:0] md, input logic [7:0] c, input logic ae,
                         input logic r, input logic [23:0] a, input logic [15:0] d);
        int k;
        int nrx;
        int nb;
        lane_mode = md;
        w = (md == MODE_QUAD) ? 3'h4 : (md == MODE_DUAL) ? 3'h2 : 3'h1;
        nb = 8 + (ae ? 24 / int'(w) : 0);
        // on writes the model stays off the lanes for the whole frame
        lead = r ? 6'(nb) : 6'h3f;
        {cmd, addr_en, rd, addr, len, tx_data, rd_byte} = {c, ae, r, a, 8'h02, d};
        repeat (3) @(negedge clk);
        start = 1'b1;
        @(negedge clk);
        k = 0;
        nrx = 0;
        while (done !== 1'b1 && k < 3000) begin
            start = (k == 40);
            if (tx_take === 1'b1) tx_data = d[7:0];
            if (rx_valid === 1'b1) begin
                chk(rx_data, d[7:0]);
                nrx++;
            end
            @(negedge clk);
            k++;
        end
        start = 1'b0;
        chk(k < 3000, 1'b1);
        chk(sel_n, 1'b1);
        chk(nrx, r ? 2 : 0);
        chk(rises, nb + 16 / int'(w));
        if (!r) chk(cap[47:0], {c, a, d});
    endtask : frame

    task automatic t_reset();
        chk({sel_n, sck, m_oe, m_out & 4'hd}, {2'h2, 4'hd, 4'hc});
        $display("test reset done");
    endtask : t_reset

    task automatic t_pins();
        for (int md = 0; md < 2; md++) begin
            lane_mode = 2'(md);
            {pause_req, wp_req} = 2'h2;
            repeat (3) @(negedge clk);
            chk(m_out[3:2], 2'h1);
            {pause_req, wp_req} = 2'h1;
            repeat (3) @(negedge clk);
            chk(m_out[3:2], 2'h2);
            {pause_req, wp_req} = 2'h0;
            repeat (3) @(negedge clk);
        end
        $display("test pins done");
    endtask : t_pins

    task automatic t_writes();
        frame(MODE_SINGLE, 8'h02, 1'b1, 1'b0, 24'h5a3c96, 16'ha51e);
        frame(MODE_DUAL, 8'ha2, 1'b1, 1'b0, 24'hc3e187, 16'h7b2d);
        frame(MODE_QUAD, 8'h32, 1'b1, 1'b0, 24'h1f2e3d, 16'hd46c);
        $display("test writes done");
    endtask : t_writes

    task automatic t_reads();
        frame(MODE_SINGLE, 8'h03, 1'b1, 1'b1, 24'h000100, 16'h00b6);
        frame(MODE_DUAL, 8'h3b, 1'b0, 1'b1, 24'h000000, 16'h00c9);
        frame(MODE_QUAD, 8'h6b, 1'b1, 1'b1, 24'h00ff00, 16'h005e);
        frame(2'h3, 8'h0b, 1'b0, 1'b1, 24'h000000, 16'h0093);
        $display("test reads done");
    endtask : t_reads

    task automatic t_quad_pause();
        {pause_req, wp_req} = 2'h3;
        frame(MODE_QUAD, 8'h38, 1'b1, 1'b0, 24'h812345, 16'h3cc3);
        {pause_req, wp_req} = 2'h0;
        lane_mode = MODE_SINGLE;
        repeat (3) @(negedge clk);
        $display("test quad pause done");
    endtask : t_quad_pause

    initial begin
        {clk, rst_b, start, addr_en, rd, pause_req, wp_req} = 7'h0;
        {lane_mode, cmd, len, tx_data, rd_byte, addr} = '0;
        {w, lead, up_q, mode_q, mode_p, req_q} = '0;
        {fails, checked, cycles, rises, cap} = '0;
        repeat (8) @(negedge clk);
        t_reset();
        rst_b = 1'b1;
        repeat (2) @(negedge clk);
        t_pins();
        t_writes();
        t_reads();
        t_quad_pause();
        end_of_test();
    end
endmodule : qlsm_master_test
